// File: count_source.sv
// Count pin source model: bursts of falling edges
module count_source (
    input wire pclk,
    input wire presetn,
    input wire go,
    input wire [3:0] n,
    output wire pin,
    output wire busy
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] left_reg;
    reg [1:0] phase_reg;
    // Two cycles low, two high: each level outlasts one sample
    assign pin = !(busy && !phase_reg[1]);
    assign busy = left_reg != 4'h0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_reg <= 4'h0;
            phase_reg <= 2'h0;
        end else if (go) begin
            left_reg <= n;
            phase_reg <= 2'h0;
        end else if (busy) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end
endmodule

// File: dual_timer_ext_irq.v
// Two timer/counters with external interrupt detection behind an APB slave
// Notes on behaviour
// - Timer ticks every 1, 12 or 96 clocks
// - Counter ticks on detected count pin falling edge
// - Gate set: count only while irq pin high
// - Counter select one counts events, zero timer
// - Mode field picks 13, 16, reload, split
// - Mode 0 low five bits carry high byte
// - Mode 2 low byte reloads from high byte
// - Mode 3 stops timer b, splits timer a
// - Overflow sets flag; software or acknowledge clears
// - Run bit cleared holds the count
// - Selected edge sets flag; acknowledge clears it
// - Type bit level/edge, polarity field picks sense
// - Deglitch filter none, 5, 10, 15 us
// - Prescaler codes div12, div1, div96, reserved
`include "timer_unit_defines.vh"
module dual_timer_ext_irq (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer_a_count_pin,
    input wire timer_b_count_pin,
    input wire irq_a_pin,
    input wire irq_b_pin,
    output wire timer_a_ovf_req,
    output wire timer_b_ovf_req,
    output wire irq_a_req,
    output wire irq_b_req,
    input wire timer_a_ack,
    input wire timer_b_ack,
    input wire irq_a_ack,
    input wire irq_b_ack,
    output wire irq
);

    // ********************************************
    // APB decode
    // ********************************************
    wire [7:0] idx = paddr[`ADDR_W-1:2];
    wire acc = psel & penable;
    wire wr = acc & pwrite & pstrb[0];
    wire hit = (idx == `IDX_CTRL) | (idx == `IDX_MODE) | (idx == `IDX_A_LOW) | (idx == `IDX_B_LOW) |
               (idx == `IDX_A_HIGH) | (idx == `IDX_B_HIGH) | (idx == `IDX_PRESC) | (idx == `IDX_TRIG) |
               (idx == `IDX_DEGL) | (idx == `IDX_IRQ_STAT) | (idx == `IDX_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    wire [7:0] wd = pwdata[7:0];

    reg [7:0] ctrl_reg;
    reg [7:0] mode_reg;
    reg [7:0] a_low_reg, a_high_reg, b_low_reg, b_high_reg;
    reg [3:0] presc_reg, trig_reg, degl_reg;
    reg [`IS_W-1:0] stat_reg, mask_reg;
    reg [31:0] rdata_reg;

    // ********************************************
    // Synchronous inputs, filtering and edges
    // ********************************************
    wire [1:0] irq_pins = {irq_b_pin, irq_a_pin};
    wire [1:0] cnt_pins = {timer_b_count_pin, timer_a_count_pin};
    wire [1:0] irq_clean;
    wire [1:0] irq_edge;
    wire [1:0] cnt_fall;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg [`DEG_CNT_W-1:0] dcnt_reg;
            reg filt_reg, filt_d_reg, cnt_d_reg, cnt_dd_reg;
            wire [1:0] fsel = degl_reg[2*g+1:2*g];
            wire [1:0] pol = trig_reg[2*g+1:2*g];
            wire [31:0] need_full = fsel * `DEG_STEP_CYC;
            wire [`DEG_CNT_W-1:0] need = need_full[`DEG_CNT_W-1:0];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dcnt_reg <= {`DEG_CNT_W{1'b0}};
                    filt_reg <= 1'b0;
                    filt_d_reg <= 1'b0;
                    cnt_d_reg <= 1'b0;
                    cnt_dd_reg <= 1'b0;
                end else begin
                    // Input must stay at its new level for the whole window
                    if (irq_pins[g] == filt_reg) begin
                        dcnt_reg <= {`DEG_CNT_W{1'b0}};
                    end else if (fsel == 2'h0 || dcnt_reg + 1'b1 >= need) begin
                        filt_reg <= irq_pins[g];
                        dcnt_reg <= {`DEG_CNT_W{1'b0}};
                    end else begin
                        dcnt_reg <= dcnt_reg + 1'b1;
                    end
                    filt_d_reg <= filt_reg;
                    // Two samples: relies on source holding each level a cycle
                    cnt_d_reg <= cnt_pins[g];
                    cnt_dd_reg <= cnt_d_reg;
                end
            end
            assign irq_clean[g] = filt_reg;
            assign cnt_fall[g] = cnt_dd_reg & ~cnt_d_reg;
            // Edge sense chosen by polarity code
            assign irq_edge[g] = (pol == `POL_LOW_FALL) ? (filt_d_reg & ~filt_reg) :
                                 (pol == `POL_HIGH_RISE) ? (~filt_d_reg & filt_reg) :
                                 (pol == `POL_BOTH) ? (filt_d_reg ^ filt_reg) : 1'b0;
        end
    endgenerate

    // ********************************************
    // Prescalers
    // ********************************************
    reg [6:0] pa_reg, pb_reg;
    wire [1:0] psa = presc_reg[1:0];
    wire [1:0] psb = presc_reg[3:2];
    wire [6:0] lasta = (psa == `PS_DIV96) ? `DIV96_LAST : `DIV12_LAST;
    wire [6:0] lastb = (psb == `PS_DIV96) ? `DIV96_LAST : `DIV12_LAST;
    // Reserved code never ticks; a count left past the end by a divider change restarts at once
    wire tick_a = (psa == `PS_DIV1) | ((psa == `PS_DIV12 || psa == `PS_DIV96) & (pa_reg >= lasta));
    wire tick_b = (psb == `PS_DIV1) | ((psb == `PS_DIV12 || psb == `PS_DIV96) & (pb_reg >= lastb));

    // ********************************************
    // Count enables
    // ********************************************
    wire [3:0] md_a = mode_reg[3:0];
    wire [3:0] md_b = mode_reg[7:4];
    wire [1:0] ma = md_a[1:0];
    wire [1:0] mb = md_b[1:0];
    wire run_a = ctrl_reg[`CTL_A_RUN];
    wire run_b = ctrl_reg[`CTL_B_RUN];
    // Counter select picks pin edges or prescaler
    wire src_a = md_a[`MD_CSEL] ? cnt_fall[0] : tick_a;
    wire src_b = md_b[`MD_CSEL] ? cnt_fall[1] : tick_b;
    // Gate needs the raw-filtered irq pin high
    wire en_a = run_a & (~md_a[`MD_GATE] | irq_clean[0]) & src_a;
    // In split mode the high half of timer a borrows timer b's run bit but counts on timer a's prescale
    wire en_ah = run_b & tick_a;
    wire en_b = run_b & (~md_b[`MD_GATE] | irq_clean[1]) & src_b & (mb != `MODE_SPLIT);

    // ********************************************
    // Next count values
    // ********************************************
    reg [7:0] a_low_next, a_high_next, b_low_next, b_high_next;
    reg ovf_a, ovf_b;
    always @* begin
        a_low_next = a_low_reg;
        a_high_next = a_high_reg;
        ovf_a = 1'b0;
        ovf_b = 1'b0;
        case (ma)
            `MODE_13: begin
                if (en_a) begin
                    // Upper three low bits forced to zero
                    a_low_next = {3'h0, a_low_reg[4:0] + 5'h01};
                    if (a_low_reg[4:0] == 5'h1f) begin
                        a_high_next = a_high_reg + 8'h01;
                        ovf_a = (a_high_reg == 8'hff);
                    end
                end
            end
            `MODE_16: begin
                if (en_a) begin
                    a_low_next = a_low_reg + 8'h01;
                    if (a_low_reg == 8'hff) begin
                        a_high_next = a_high_reg + 8'h01;
                        ovf_a = (a_high_reg == 8'hff);
                    end
                end
            end
            `MODE_RELOAD: begin
                if (en_a) begin
                    a_low_next = (a_low_reg == 8'hff) ? a_high_reg : a_low_reg + 8'h01;
                    ovf_a = (a_low_reg == 8'hff);
                end
            end
            default: begin
                // Two independent 8-bit halves
                if (en_a) begin
                    a_low_next = a_low_reg + 8'h01;
                    ovf_a = (a_low_reg == 8'hff);
                end
                if (en_ah) begin
                    a_high_next = a_high_reg + 8'h01;
                    ovf_b = (a_high_reg == 8'hff);
                end
            end
        endcase
        b_low_next = b_low_reg;
        b_high_next = b_high_reg;
        if (en_b) begin
            case (mb)
                `MODE_13: begin
                    b_low_next = {3'h0, b_low_reg[4:0] + 5'h01};
                    if (b_low_reg[4:0] == 5'h1f) begin
                        b_high_next = b_high_reg + 8'h01;
                        ovf_b = ovf_b | (b_high_reg == 8'hff);
                    end
                end
                `MODE_16: begin
                    b_low_next = b_low_reg + 8'h01;
                    if (b_low_reg == 8'hff) begin
                        b_high_next = b_high_reg + 8'h01;
                        ovf_b = ovf_b | (b_high_reg == 8'hff);
                    end
                end
                `MODE_RELOAD: begin
                    b_low_next = (b_low_reg == 8'hff) ? b_high_reg : b_low_reg + 8'h01;
                    ovf_b = ovf_b | (b_low_reg == 8'hff);
                end
                default: begin
                    b_low_next = b_low_reg;
                end
            endcase
        end
    end

    // ********************************************
    // Flags
    // ********************************************
    wire set_a_edge = ctrl_reg[`CTL_A_TYPE] & irq_edge[0];
    wire set_b_edge = ctrl_reg[`CTL_B_TYPE] & irq_edge[1];
    wire ctrl_wr = wr & (idx == `IDX_CTRL);
    reg [7:0] ctrl_next;
    always @* begin
        ctrl_next = ctrl_wr ? wd : ctrl_reg;
        // Acknowledge clears, but a new event in the same cycle wins
        if (timer_a_ack) ctrl_next[`CTL_A_OVF] = 1'b0;
        if (timer_b_ack) ctrl_next[`CTL_B_OVF] = 1'b0;
        if (irq_a_ack) ctrl_next[`CTL_A_EDGE] = 1'b0;
        if (irq_b_ack) ctrl_next[`CTL_B_EDGE] = 1'b0;
        if (ovf_a) ctrl_next[`CTL_A_OVF] = 1'b1;
        if (ovf_b) ctrl_next[`CTL_B_OVF] = 1'b1;
        if (set_a_edge) ctrl_next[`CTL_A_EDGE] = 1'b1;
        if (set_b_edge) ctrl_next[`CTL_B_EDGE] = 1'b1;
    end

    // Level-trigger requests follow the filtered pin
    wire lvl_a = ~ctrl_reg[`CTL_A_TYPE] & ((trig_reg[1:0] == `POL_LOW_FALL) ? ~irq_clean[0] :
                 (trig_reg[1:0] == `POL_HIGH_RISE) ? irq_clean[0] : 1'b0);
    wire lvl_b = ~ctrl_reg[`CTL_B_TYPE] & ((trig_reg[3:2] == `POL_LOW_FALL) ? ~irq_clean[1] :
                 (trig_reg[3:2] == `POL_HIGH_RISE) ? irq_clean[1] : 1'b0);
    assign timer_a_ovf_req = ctrl_reg[`CTL_A_OVF];
    assign timer_b_ovf_req = ctrl_reg[`CTL_B_OVF];
    assign irq_a_req = ctrl_reg[`CTL_A_EDGE] | lvl_a;
    assign irq_b_req = ctrl_reg[`CTL_B_EDGE] | lvl_b;

    reg irq_a_req_d, irq_b_req_d;
    wire [`IS_W-1:0] ev = {set_b_edge | (lvl_b & ~irq_b_req_d), set_a_edge | (lvl_a & ~irq_a_req_d), ovf_b, ovf_a};
    assign irq = |(stat_reg & mask_reg);

    // ********************************************
    // Registers
    // ********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 8'h00;
            mode_reg <= 8'h00;
            a_low_reg <= 8'h00;
            a_high_reg <= 8'h00;
            b_low_reg <= 8'h00;
            b_high_reg <= 8'h00;
            presc_reg <= 4'h0;
            trig_reg <= 4'h0;
            degl_reg <= 4'h0;
            stat_reg <= {`IS_W{1'b0}};
            mask_reg <= {`IS_W{1'b0}};
            pa_reg <= 7'h00;
            pb_reg <= 7'h00;
            irq_a_req_d <= 1'b0;
            irq_b_req_d <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            irq_a_req_d <= lvl_a;
            irq_b_req_d <= lvl_b;
            pa_reg <= (tick_a || psa == `PS_DIV1) ? 7'h00 : pa_reg + 7'h01;
            pb_reg <= (tick_b || psb == `PS_DIV1) ? 7'h00 : pb_reg + 7'h01;
            // Software write to a count byte overrides the increment
            a_low_reg <= (wr && idx == `IDX_A_LOW) ? wd : a_low_next;
            a_high_reg <= (wr && idx == `IDX_A_HIGH) ? wd : a_high_next;
            b_low_reg <= (wr && idx == `IDX_B_LOW) ? wd : b_low_next;
            b_high_reg <= (wr && idx == `IDX_B_HIGH) ? wd : b_high_next;
            if (wr && idx == `IDX_MODE) mode_reg <= wd;
            if (wr && idx == `IDX_PRESC) presc_reg <= wd[3:0];
            if (wr && idx == `IDX_TRIG) trig_reg <= wd[3:0];
            if (wr && idx == `IDX_DEGL) degl_reg <= wd[3:0];
            if (wr && idx == `IDX_IRQ_MASK) mask_reg <= wd[`IS_W-1:0];
            // Write one to clear; new event wins
            stat_reg <= (stat_reg & ~((wr && idx == `IDX_IRQ_STAT) ? wd[`IS_W-1:0] : {`IS_W{1'b0}})) | ev;
            if (psel && !penable && !pwrite) begin
                case (idx)
                    `IDX_CTRL: rdata_reg <= {24'h0, ctrl_reg};
                    `IDX_MODE: rdata_reg <= {24'h0, mode_reg};
                    `IDX_A_LOW: rdata_reg <= {24'h0, a_low_reg};
                    `IDX_B_LOW: rdata_reg <= {24'h0, b_low_reg};
                    `IDX_A_HIGH: rdata_reg <= {24'h0, a_high_reg};
                    `IDX_B_HIGH: rdata_reg <= {24'h0, b_high_reg};
                    `IDX_PRESC: rdata_reg <= {28'h0, presc_reg};
                    `IDX_TRIG: rdata_reg <= {28'h0, trig_reg};
                    `IDX_DEGL: rdata_reg <= {28'h0, degl_reg};
                    `IDX_IRQ_STAT: rdata_reg <= {28'h0, stat_reg};
                    `IDX_IRQ_MASK: rdata_reg <= {28'h0, mask_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign prdata = rdata_reg;
endmodule

// File: test_dual_timer_ext_interrupt_unit.sv
// Self-checking bench of the dual timer unit
`include "timer_unit_defines.vh"
module test_dual_timer_ext_interrupt_unit;
    timeunit 1ns;
    timeprecision 1ps;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [9:0] paddr = 10'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [3:0] pstrb = 4'h0;
    reg [1:0] pin_irq = 2'h3;
    reg [3:0] acks = 4'h0;
    reg [1:0] go = 2'h0;
    reg [7:0] pulses = 8'h00;
    reg [31:0] seed = 32'h00002df3;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [1:0] cpin;
    wire [1:0] busy;
    wire [1:0] ovf;
    wire [1:0] ireq;
    wire irq;
    int n_errors = 0;
    int num_checks = 0;
    int n;
    int t;
    int d;
    dual_timer_ext_irq dual_timer_ext_irq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_a_count_pin(cpin[0]), .timer_b_count_pin(cpin[1]), .irq_a_pin(pin_irq[0]),
        .irq_b_pin(pin_irq[1]), .timer_a_ovf_req(ovf[0]), .timer_b_ovf_req(ovf[1]), .irq_a_req(ireq[0]),
        .irq_b_req(ireq[1]), .timer_a_ack(acks[0]), .timer_b_ack(acks[1]), .irq_a_ack(acks[2]),
        .irq_b_ack(acks[3]), .irq(irq));
    count_source count_source_i[1:0] (.pclk(pclk), .presetn(presetn), .go(go), .n(pulses), .pin(cpin),
        .busy(busy));
    // ****************
    // Helpers
    // ****************
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function int div_of(input int p);
        return p == 0 ? 12 : (p == 1 ? 1 : 96);
    endfunction
    function logic edge_hit(input int pol, input int start);
        return pol == 2 || (pol == 0) == (start == 1);
    endfunction
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, v};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v);
    endtask
    task rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask
    task wait_ovf(input int ch, input int lim);
        n = 0;
        while (ovf[ch] !== 1'b1 && n < lim) begin
            @(negedge pclk);
            n++;
        end
    endtask
    task ack(input logic [3:0] m);
        @(posedge pclk);
        acks <= m;
        @(posedge pclk);
        acks <= 4'h0;
        @(posedge pclk);
    endtask
    task pulse(input int ch, input logic [3:0] k);
        @(posedge pclk);
        go[ch] <= 1'b1;
        pulses[4*ch+:4] <= k;
        @(posedge pclk);
        go[ch] <= 1'b0;
        @(posedge pclk);
        while (busy[ch] !== 1'b0) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 8'h88; i <= 8'h8d; i++) rdc("reset", i[7:0], 0);
        apb(1'b0, 8'h90, 8'h00);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        wr(`IDX_PRESC, xs() & 8'h0f);
        rdc("readback", `IDX_PRESC, seed & 8'h0f);
        done("registers");
        for (int m = 0; m < 3; m++) for (int p = 0; p < 4; p++) begin
            t = xs() % 16 + 1;
            d = div_of(p);
            wr(`IDX_CTRL, 8'h00);
            wr(`IDX_MODE, m);
            wr(`IDX_PRESC, p);
            wr(`IDX_A_HIGH, m == 2 ? 8'ha5 : 8'hff);
            wr(`IDX_A_LOW, (m == 0 ? 32'h20 : 32'h100) - t);
            wr(`IDX_CTRL, 8'h10);
            wait_ovf(0, p == 3 ? 300 : t * d + 20);
            if (p == 3) check("no tick", ovf[0], 0);
            else check("ovf time", n >= (t - 1) * d && n <= t * d + 4, 1);
            apb(1'b0, `IDX_CTRL, 8'h00);
            check("flag", rd[5], p != 3);
            wr(`IDX_CTRL, 8'h00);
            apb(1'b0, `IDX_A_LOW, 8'h00);
            if (m == 0) check("low top zero", rd[7:5], 0);
            if (m == 2 && p != 3) check("reloaded", rd >= 8'ha5, 1);
            rdc("hold", `IDX_A_LOW, rd);
        end
        done("modes");
        wr(`IDX_CTRL, 8'haf);
        @(negedge pclk);
        check("flags set", {ireq, ovf}, 4'hf);
        ack(4'hf);
        check("flags acked", {ireq, ovf}, 4'h0);
        wr(`IDX_MODE, 8'h03);
        wr(`IDX_PRESC, 8'h01);
        wr(`IDX_A_HIGH, 8'hfa);
        wr(`IDX_CTRL, 8'h40);
        wait_ovf(1, 30);
        check("split high", n >= 5 && n <= 10, 1);
        wr(`IDX_CTRL, 8'h00);
        wr(`IDX_MODE, 8'h30);
        wr(`IDX_B_LOW, 8'hff);
        wr(`IDX_B_HIGH, 8'hff);
        wr(`IDX_PRESC, 8'h05);
        wr(`IDX_CTRL, 8'h40);
        repeat (50) @(posedge pclk);
        check("b stopped", ovf[1], 0);
        rdc("b held", `IDX_B_LOW, 8'hff);
        done("split");
        for (int ch = 0; ch < 2; ch++) begin
            wr(`IDX_CTRL, 8'h00);
            wr(`IDX_MODE, ch ? 8'h50 : 8'h05);
            wr(8'h8a + ch, 8'hfd);
            wr(8'h8c + ch, 8'hff);
            wr(`IDX_CTRL, ch ? 8'h40 : 8'h10);
            pulse(ch, 4'h2);
            check("two events", ovf[ch], 0);
            rdc("count", 8'h8a + ch, 8'hff);
            pulse(ch, 4'h1);
            check("third event", ovf[ch], 1);
        end
        done("counter");
        wr(`IDX_DEGL, 8'h00);
        wr(`IDX_CTRL, 8'h00);
        pin_irq <= 2'h2;
        wr(`IDX_MODE, 8'h09);
        wr(`IDX_A_LOW, 8'hf0);
        wr(`IDX_A_HIGH, 8'hff);
        wr(`IDX_PRESC, 8'h01);
        wr(`IDX_CTRL, 8'h10);
        repeat (40) @(posedge pclk);
        rdc("gated", `IDX_A_LOW, 8'hf0);
        pin_irq <= 2'h3;
        wait_ovf(0, 40);
        check("gate open", ovf[0], 1);
        done("gate");
        @(posedge pclk);
        for (int e = 0; e < 6; e++) begin
            pin_irq <= {2{e[0]}};
            wr(`IDX_TRIG, (e / 2) * 5);
            wr(`IDX_CTRL, 8'h05);
            pin_irq <= {2{~e[0]}};
            repeat (8) @(posedge pclk);
            check("edge", ireq, {2{edge_hit(e / 2, e % 2)}});
            ack(4'hc);
            check("edge acked", ireq, 2'h0);
        end
        wr(`IDX_CTRL, 8'h00);
        for (int e = 0; e < 4; e++) begin
            wr(`IDX_TRIG, (e / 2) * 5);
            pin_irq <= {2{e[0]}};
            repeat (6) @(posedge pclk);
            check("level", ireq, {2{e[0] == e[1]}});
        end
        done("edges");
        wr(`IDX_TRIG, 8'h01);
        for (int f = 1; f < 4; f++) begin
            wr(`IDX_DEGL, f);
            pin_irq <= 2'h0;
            repeat (f * 500 + 100) @(posedge pclk);
            pin_irq <= 2'h1;
            repeat (f * 500 - 50) @(posedge pclk);
            check("filter hold", ireq[0], 0);
            repeat (100) @(posedge pclk);
            check("filter pass", ireq[0], 1);
        end
        done("deglitch");
        wr(`IDX_DEGL, 8'h00);
        wr(`IDX_CTRL, 8'h05);
        wr(`IDX_IRQ_MASK, 8'h00);
        wr(`IDX_IRQ_STAT, 8'h0f);
        wr(`IDX_MODE, 8'h01);
        wr(`IDX_A_LOW, 8'hff);
        wr(`IDX_A_HIGH, 8'hff);
        wr(`IDX_CTRL, 8'h15);
        wait_ovf(0, 20);
        wr(`IDX_CTRL, 8'h05);
        apb(1'b0, `IDX_IRQ_STAT, 8'h00);
        check("status", {rd[0], irq}, 2'h2);
        wr(`IDX_IRQ_MASK, 8'h01);
        @(negedge pclk);
        check("unmasked", irq, 1);
        wr(`IDX_IRQ_STAT, 8'h01);
        @(negedge pclk);
        check("cleared", irq, 0);
        done("interrupt");
        wrap_up;
    end
endmodule

// File: timer_unit_chk_props.sv
// Port assertions of the dual timer unit
`include "timer_unit_defines.vh"
module timer_unit_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire timer_a_ovf_req,
    input wire timer_b_ovf_req,
    input wire timer_a_ack,
    input wire timer_b_ack,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Bus decode
    // ****************
    wire acc = psel && penable;
    wire [7:0] idx = paddr[9:2];
    wire hit = (idx >= `IDX_CTRL && idx <= `IDX_B_HIGH) || idx == `IDX_PRESC || idx == `IDX_TRIG
        || idx == `IDX_DEGL || idx == `IDX_IRQ_STAT || idx == `IDX_IRQ_MASK;
    wire ctl_wr = acc && pwrite && pstrb[0] && idx == `IDX_CTRL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Flags drop only on acknowledge or software write
    chk_a_flag_fall: assert property (
        $fell(timer_a_ovf_req) |-> $past(timer_a_ack) || $past(ctl_wr)) else $error("a flag fell unasked");
    chk_b_flag_fall: assert property (
        $fell(timer_b_ovf_req) |-> $past(timer_b_ack) || $past(ctl_wr)) else $error("b flag fell unasked");
    // An overflow in the ack cycle would win; bench acks stopped timers only
    chk_a_ack_clear: assert property (
        timer_a_ack && !psel |=> !timer_a_ovf_req) else $error("a ack did not clear");
    chk_b_ack_clear: assert property (
        timer_b_ack && !psel |=> !timer_b_ovf_req) else $error("b ack did not clear");
    chk_reset_quiet: assert property (
        $rose(presetn) |-> !timer_a_ovf_req && !timer_b_ovf_req && !irq) else $error("flags set after reset");
    chk_err_mapped: assert property (
        acc && hit |-> !pslverr) else $error("error on mapped register");
    chk_err_unmapped: assert property (
        acc && !hit |-> pslverr) else $error("no error on unmapped register");
    chk_read_upper: assert property (
        acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("read data upper bits set");
endmodule
bind dual_timer_ext_irq timer_unit_chk timer_unit_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .timer_a_ovf_req(timer_a_ovf_req), .timer_b_ovf_req(timer_b_ovf_req), .timer_a_ack(timer_a_ack),
    .timer_b_ack(timer_b_ack), .irq(irq));

// File: timer_unit_defines.vh
// Register map, field positions and timing constants of the dual timer unit
`ifndef TIMER_UNIT_DEFINES_VH
`define TIMER_UNIT_DEFINES_VH

// ********************************************
// Register indices and address width
// ********************************************
`define IDX_CTRL 8'h88
`define IDX_MODE 8'h89
`define IDX_A_LOW 8'h8a
`define IDX_B_LOW 8'h8b
`define IDX_A_HIGH 8'h8c
`define IDX_B_HIGH 8'h8d
`define IDX_PRESC 8'hd9
`define IDX_TRIG 8'he5
`define IDX_DEGL 8'hee
`define IDX_IRQ_STAT 8'hf8
`define IDX_IRQ_MASK 8'hf9
`define ADDR_W 10

// ********************************************
// Control register bits
// ********************************************
`define CTL_B_OVF 7
`define CTL_B_RUN 6
`define CTL_A_OVF 5
`define CTL_A_RUN 4
`define CTL_B_EDGE 3
`define CTL_B_TYPE 2
`define CTL_A_EDGE 1
`define CTL_A_TYPE 0

// ********************************************
// Mode nibble layout and modes
// ********************************************
`define MD_GATE 3
`define MD_CSEL 2
`define MODE_13 2'h0
`define MODE_16 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3

// ********************************************
// Prescaler codes and dividers
// ********************************************
`define PS_DIV12 2'h0
`define PS_DIV1 2'h1
`define PS_DIV96 2'h2
`define DIV12_LAST 7'h0b
`define DIV96_LAST 7'h5f

// ********************************************
// Trigger polarity codes
// ********************************************
`define POL_LOW_FALL 2'h0
`define POL_HIGH_RISE 2'h1
`define POL_BOTH 2'h2

// ********************************************
// Deglitch timing
// ********************************************
`define CLK_MHZ 100
`define DEG_STEP_US 5
`define DEG_STEP_CYC (`DEG_STEP_US * `CLK_MHZ)
`define DEG_CNT_W 11

// ********************************************
// Interrupt status bits
// ********************************************
`define IS_A_OVF 0
`define IS_B_OVF 1
`define IS_A_IRQ 2
`define IS_B_IRQ 3
`define IS_W 4

`endif
